// ===== logic/adcgr_config.sv
// module: gain, rate and conversion delay configuration of the converter
`timescale 1ns/1ns
`default_nettype none
module adcgr_config (
  input wire logic mclk,
  input wire logic rst_b,
  input wire adcgr_pkg::adcgr_cmd_t cmd,
  input wire logic ext_clk_pin,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output adcgr_pkg::adcgr_cfg_t cfg,
  output logic [7:0] ref_ctrl,
  output logic delay_busy,
  output logic conv_start
);
  import adcgr_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] amplifier_gain_setting_r;
  logic [7:0] conversion_rate_control_r;
  logic [7:0] reference_control_r;
  logic wr_gain, wr_rate, qual_wr;

  assign wr_gain = cmd.wr && (cmd.addr == GAIN_REG_ADDR);
  assign wr_rate = cmd.wr && (cmd.addr == RATE_REG_ADDR);
  assign qual_wr = wr_gain || wr_rate;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      amplifier_gain_setting_r <= GAIN_REG_RST;
      conversion_rate_control_r <= RATE_REG_RST;
      reference_control_r <= REF_REG_RST;
    end else begin
      if (wr_gain) begin
        amplifier_gain_setting_r <= cmd.data;
      end
      if (wr_rate) begin
        conversion_rate_control_r <= cmd.data;
      end
      if (cmd.wr && (cmd.addr == REF_REG_ADDR)) begin
        reference_control_r <= cmd.data;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cmd.rd;
      if (cmd.rd) begin
        case (cmd.addr)
          GAIN_REG_ADDR: rd_data <= amplifier_gain_setting_r;
          RATE_REG_ADDR: rd_data <= conversion_rate_control_r;
          REF_REG_ADDR: rd_data <= reference_control_r;
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end
  assign ref_ctrl = reference_control_r;

  // ----------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------
  logic [2:0] delay_f, gain_f;
  logic [1:0] amp_f;
  logic [3:0] rate_f;
  assign delay_f = amplifier_gain_setting_r[DELAY_LSB +: 3];
  assign amp_f = amplifier_gain_setting_r[AMP_LSB +: 2];
  assign gain_f = amplifier_gain_setting_r[GAIN_LSB +: 3];
  assign rate_f = conversion_rate_control_r[RATE_LSB +: 4];

  function automatic logic [11:0] delay_count(input logic [2:0] code);
    case (code)
      3'h0: delay_count = DLY_C0;
      3'h1: delay_count = DLY_C1;
      3'h2: delay_count = DLY_C2;
      3'h3: delay_count = DLY_C3;
      3'h4: delay_count = DLY_C4;
      3'h5: delay_count = DLY_C5;
      3'h7: delay_count = DLY_C7;
      default: delay_count = DLY_C0;
    endcase
  endfunction

  // rate in tenths of a sample per second, zero when reserved
  function automatic logic [15:0] rate_tenths(input logic [3:0] code);
    case (code)
      4'h0: rate_tenths = 16'h0019;
      4'h1: rate_tenths = 16'h0032;
      4'h2: rate_tenths = 16'h0064;
      4'h3: rate_tenths = 16'h00A6;
      4'h4: rate_tenths = 16'h00C8;
      4'h5: rate_tenths = 16'h01F4;
      4'h6: rate_tenths = 16'h0258;
      4'h8: rate_tenths = 16'h07D0;
      4'h9: rate_tenths = 16'h0FA0;
      4'hB: rate_tenths = 16'h2710;
      4'hD: rate_tenths = 16'h9C40;
      default: rate_tenths = 16'h0000;
    endcase
  endfunction

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= '0;
    end else begin
      cfg.chop_en <= conversion_rate_control_r[CHOP_BIT];
      cfg.ext_clk_sel <= conversion_rate_control_r[CLKSEL_BIT];
      cfg.single_shot <= conversion_rate_control_r[MODE_BIT];
      cfg.low_latency <= conversion_rate_control_r[FILT_BIT];
      cfg.output_rate_code <= rate_f;
      cfg.rate_valid <= (rate_tenths(rate_f) != 16'h0000);
      cfg.rate_tenths <= rate_tenths(rate_f);
      cfg.amp_power_on <= (amp_f == AMP_ON);
      cfg.amp_bypass <= (amp_f != AMP_ON);
      cfg.gain_factor <= (amp_f == AMP_ON) ? (8'h01 << gain_f) : 8'h01;
      cfg.gain_misset <= (amp_f == AMP_BYPASS) && (gain_f != 3'h0);
    end
  end

  // ----------------------------------------------------------------------
  // modulator period ticks
  // ----------------------------------------------------------------------
  logic ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r, ext_edge;
  logic tick_int, tick_ext, mod_tick;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clk_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r) begin
        ext_lvl_r <= ext_s3_r;
      end
    end
  end
  assign ext_edge = ext_s2_r && ext_s3_r && !ext_lvl_r;

  adcgr_tick_div #(.N(MOD_DIV_INT)) u_int_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .en(1'b1),
    .tick(tick_int)
  );
  adcgr_tick_div #(.N(EXT_DIV)) u_ext_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .en(ext_edge),
    .tick(tick_ext)
  );
  assign mod_tick = conversion_rate_control_r[CLKSEL_BIT] ?
    tick_ext : tick_int;

  // ----------------------------------------------------------------------
  // conversion start delay
  // ----------------------------------------------------------------------
  logic [DLY_W-1:0] dly_cnt_r;
  logic [2:0] new_delay;
  assign new_delay = wr_gain ? cmd.data[DELAY_LSB +: 3] : delay_f;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dly_cnt_r <= '0;
      delay_busy <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (qual_wr) begin
        dly_cnt_r <= delay_count(new_delay);
        delay_busy <= 1'b1;
      end else if (delay_busy && mod_tick) begin
        if (dly_cnt_r == DLY_W'(1)) begin
          delay_busy <= 1'b0;
          conv_start <= 1'b1;
        end
        dly_cnt_r <= dly_cnt_r - DLY_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_wr_starts_wait;
    @(posedge mclk) disable iff (!rst_b) qual_wr |=> delay_busy;
  endproperty
  a_wr_starts_wait: assert property (p_wr_starts_wait)
    else $error("qualifying write did not start the wait");

  property p_code0_count;
    @(posedge mclk) disable iff (!rst_b)
      (qual_wr && new_delay == 3'h0) |=> (dly_cnt_r == 12'h00E);
  endproperty
  a_code0_count: assert property (p_code0_count)
    else $error("delay code 000 did not load 14 periods");

  property p_code5_count;
    @(posedge mclk) disable iff (!rst_b)
      (qual_wr && new_delay == 3'h5) |=> (dly_cnt_r == 12'h800);
  endproperty
  a_code5_count: assert property (p_code5_count)
    else $error("delay code 101 did not load 2048 periods");

  property p_start_cause;
    @(posedge mclk) disable iff (!rst_b)
      conv_start |-> $past(delay_busy) && $past(mod_tick)
        && ($past(dly_cnt_r) == 12'h001) && !delay_busy;
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("conversion start without the last modulator period");

  property p_last_tick_starts;
    @(posedge mclk) disable iff (!rst_b)
      (delay_busy && mod_tick && !qual_wr && dly_cnt_r == 12'h001)
        |=> conv_start ##1 !conv_start;
  endproperty
  a_last_tick_starts: assert property (p_last_tick_starts)
    else $error("wait ended without a one-cycle start pulse");

  property p_amp_on;
    @(posedge mclk) disable iff (!rst_b)
      (amp_f == AMP_ON) |=> cfg.amp_power_on && !cfg.amp_bypass
        && (cfg.gain_factor == (8'h01 << $past(gain_f)));
  endproperty
  a_amp_on: assert property (p_amp_on)
    else $error("enabled amplifier shows wrong power or gain");

  property p_amp_bypass;
    @(posedge mclk) disable iff (!rst_b)
      (amp_f == AMP_BYPASS) |=> !cfg.amp_power_on && cfg.amp_bypass
        && (cfg.gain_factor == 8'h01);
  endproperty
  a_amp_bypass: assert property (p_amp_bypass)
    else $error("bypassed amplifier still powered");

  property p_rate_bits;
    @(posedge mclk) disable iff (!rst_b)
      wr_rate |=> ##1 (cfg.chop_en == $past(cmd.data[7], 2))
        && (cfg.ext_clk_sel == $past(cmd.data[6], 2))
        && (cfg.single_shot == $past(cmd.data[5], 2))
        && (cfg.low_latency == $past(cmd.data[4], 2));
  endproperty
  a_rate_bits: assert property (p_rate_bits)
    else $error("rate register bits not reflected in configuration");

  property p_rate_20;
    @(posedge mclk) disable iff (!rst_b)
      (rate_f == 4'h4) |=> (cfg.rate_tenths == 16'h00C8) && cfg.rate_valid;
  endproperty
  a_rate_20: assert property (p_rate_20)
    else $error("rate code 0100 is not 20 samples per second");

  property p_rate_reserved;
    @(posedge mclk) disable iff (!rst_b)
      (rate_f == 4'hF || rate_f == 4'h7) |=> !cfg.rate_valid;
  endproperty
  a_rate_reserved: assert property (p_rate_reserved)
    else $error("reserved rate code reported valid");
endmodule
`default_nettype wire

// ===== logic/adcgr_pkg.sv
// package: constants and types for the converter configuration block
`default_nettype none
package adcgr_pkg;
  // ----------------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] GAIN_REG_ADDR = 8'h03;
  localparam logic [7:0] RATE_REG_ADDR = 8'h04;
  localparam logic [7:0] REF_REG_ADDR = 8'h05;
  localparam logic [7:0] GAIN_REG_RST = 8'h00;
  localparam logic [7:0] RATE_REG_RST = 8'h14;
  localparam logic [7:0] REF_REG_RST = 8'h10;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int DELAY_LSB = 5;
  localparam int AMP_LSB = 3;
  localparam int GAIN_LSB = 0;
  localparam int CHOP_BIT = 7;
  localparam int CLKSEL_BIT = 6;
  localparam int MODE_BIT = 5;
  localparam int FILT_BIT = 4;
  localparam int RATE_LSB = 0;
  localparam logic [1:0] AMP_BYPASS = 2'h0;
  localparam logic [1:0] AMP_ON = 2'h1;
  // ----------------------------------------------------------------------
  // timing: modulator period from the 4.096 MHz source divided by 16
  // ----------------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 20;
  localparam int MOD_PERIOD_PS = 3906250;
  localparam int MOD_DIV_INT = MOD_PERIOD_PS / (MCLK_PERIOD_NS * 1000);
  localparam int EXT_DIV = 16;
  localparam int DIV_W = 8;
  localparam int DLY_W = 12;
  localparam logic [11:0] DLY_C0 = 12'h00E;
  localparam logic [11:0] DLY_C1 = 12'h019;
  localparam logic [11:0] DLY_C2 = 12'h040;
  localparam logic [11:0] DLY_C3 = 12'h100;
  localparam logic [11:0] DLY_C4 = 12'h400;
  localparam logic [11:0] DLY_C5 = 12'h800;
  localparam logic [11:0] DLY_C7 = 12'h001;
  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } adcgr_cmd_t;
  typedef struct packed {
    logic chop_en;
    logic ext_clk_sel;
    logic single_shot;
    logic low_latency;
    logic [3:0] output_rate_code;
    logic rate_valid;
    logic [15:0] rate_tenths;
    logic amp_power_on;
    logic amp_bypass;
    logic [7:0] gain_factor;
    logic gain_misset;
  } adcgr_cfg_t;
endpackage
`default_nettype wire

// ===== logic/adcgr_tick_div.sv
// module: enable-driven divider giving one pulse every N enables
`timescale 1ns/1ns
`default_nettype none
module adcgr_tick_div #(
  parameter int N = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic en,
  output logic tick
);
  import adcgr_pkg::*;
  logic [DIV_W-1:0] cnt_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (en) begin
      if (cnt_r == DIV_W'(N - 1)) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + DIV_W'(1);
      end
    end
  end
  assign tick = en && (cnt_r == DIV_W'(N - 1));
endmodule
`default_nettype wire

// ===== dv/adcgr_bench.sv
// testbench: register, gain, rate and conversion wait checks
`timescale 1ns/1ns
`default_nettype none
module adc_gain_rate_config_bench;
  import adcgr_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic ext_run = 1'b0;
  adcgr_cmd_t cmd = '0;
  wire logic [7:0] rd_data;
  wire logic rd_valid;
  wire adcgr_cfg_t cfg;
  wire logic [7:0] ref_ctrl;
  wire logic delay_busy;
  wire logic conv_start;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] exp_q [$];
  // rate in tenths of a sample per second, 0 where reserved
  localparam logic [15:0] RT [16] = '{16'h0019, 16'h0032, 16'h0064,
    16'h00A6, 16'h00C8, 16'h01F4, 16'h0258, 16'h0000, 16'h07D0, 16'h0FA0,
    16'h0000, 16'h2710, 16'h0000, 16'h9C40, 16'h0000, 16'h0000};
  localparam int DN [8] = '{14, 25, 64, 256, 1024, 2048, 14, 1};

  always #10 mclk = ~mclk;
  // external clock, stands still unless enabled
  always #40 if (ext_run) ext_clk_pin = ~ext_clk_pin;

  adcgr_config DUT (
    .mclk(mclk),
    .rst_b(rst_b),
    .cmd(cmd),
    .ext_clk_pin(ext_clk_pin),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .cfg(cfg),
    .ref_ctrl(ref_ctrl),
    .delay_busy(delay_busy),
    .conv_start(conv_start)
  );

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd.wr = 1'b1;
    cmd.addr = a;
    cmd.data = d;
    step();
    cmd.wr = 1'b0;
    step();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cmd.rd = 1'b1;
    cmd.addr = a;
    step();
    cmd.rd = 1'b0;
    step();
  endtask

  task automatic dly(input int c, input bit again);
    int n;
    int lo;
    int hi;
    wr(8'h03, {c[2:0], AMP_ON, 3'h0});
    if (again) begin
      repeat (1000) begin
        step();
        chk(16'(conv_start), 16'h0000);
      end
      wr(8'h03, {c[2:0], AMP_ON, 3'h0});
    end
    // first tick lands 1..195 cycles after the write edge
    lo = (DN[c] - 1) * MOD_DIV_INT + 1;
    hi = DN[c] * MOD_DIV_INT;
    n = 1;
    chk(16'(delay_busy | conv_start), 16'h0001);
    while (conv_start !== 1'b1 && n <= hi) begin
      step();
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
    step();
    chk(16'({conv_start, delay_busy}), 16'h0000);
  endtask

  // ----------------------------------------------------------------------
  // read monitor: oldest note against each returned byte
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) begin
      chk(16'(exp_q.size() != 0), 16'h0001);
      if (exp_q.size() != 0) begin
        chk(16'(rd_data), 16'(exp_q.pop_front()));
      end
    end
  end

  initial begin
    #1800000;
    n_fail++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] d;
    logic [2:0] gv;
    void'($urandom(32'hEA7B));
    repeat (10) @(posedge mclk);
    #2;
    rst_b = 1'b1;
    step();
    chk(16'({cfg.chop_en, cfg.ext_clk_sel, cfg.single_shot, cfg.low_latency,
      cfg.output_rate_code}), 16'h0014);
    chk(cfg.rate_tenths, 16'h00C8);
    chk(16'({cfg.amp_power_on, cfg.amp_bypass, cfg.gain_factor}),
      16'h0101);
    chk(16'({ref_ctrl, delay_busy}), 16'h0020);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h14);
    rd(8'h05, 8'h10);
    rd(8'h7F, 8'h00);
    d = 8'($urandom);
    wr(8'h05, d);
    chk(16'({ref_ctrl, delay_busy}), 16'({d, 1'b0}));
    rd(8'h05, d);
    for (int g = 0; g < 8; g++) begin
      // every delay code is loaded once, then overwritten
      wr(8'h03, {g[2:0], AMP_ON, g[2:0]});
      chk(16'(cfg.gain_factor), 16'(1 << g));
      chk(16'({cfg.amp_power_on, cfg.amp_bypass, cfg.gain_misset}),
        16'h0004);
    end
    for (int a = 0; a < 4; a++) begin
      if (a != 1) begin
        gv = 3'($urandom_range(7, 1));
        d = {3'h7, a[1:0], gv};
        wr(8'h03, d);
        chk(16'({cfg.amp_power_on, cfg.amp_bypass, cfg.gain_misset,
          cfg.gain_factor}), {5'h0, 2'h1, a == 0, 8'h01});
        rd(8'h03, d);
      end
    end
    for (int c = 0; c < 16; c++) begin
      d = {4'($urandom), c[3:0]};
      wr(8'h04, d);
      chk(16'({cfg.chop_en, cfg.ext_clk_sel, cfg.single_shot,
        cfg.low_latency, cfg.output_rate_code}), 16'(d));
      chk(cfg.rate_tenths, RT[c]);
      chk(16'(cfg.rate_valid), 16'(RT[c] != 0));
      rd(8'h04, d);
    end
    wr(8'h04, 8'h14);
    wr(8'h03, 8'hE8);
    repeat (200) step();
    wr(8'h04, 8'h54);
    repeat (300) begin
      step();
      chk(16'(conv_start), 16'h0000);
    end
    ext_run = 1'b1;
    n = 0;
    while (conv_start !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    chk(16'(conv_start), 16'h0001);
    ext_run = 1'b0;
    wr(8'h04, 8'h14);
    dly(7, 1'b0);
    dly(0, 1'b1);
    dly(6, 1'b0);
    dly(1, 1'b0);
    dly(2, 1'b0);
    dly(3, 1'b0);
    repeat (4) step();
    chk(16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
